// File: rtl/sss_pkg.sv
// package: constants, types and register map of the sensor serial slave
// ============================================================
// Overview of operation
// [R1] write: address+write, command, data, stop; every byte acked, data stored at command
// [R2] read: address+write, command, repeated start, address+read, one data byte, nack
// [R3] send byte only loads the register pointer, no register changes
// [R4] host never writes register data with a send byte transaction
// [R5] receive byte returns register at pointer and leaves pointer unchanged
// [R6] slave only: never starts transactions, never makes start or stop
// [R7] answers the alert response address with its own address
// [R8] answers one fixed 7-bit slave address chosen per variant
// [R9] wrong address or unsupported sequence: no ack, registers unchanged
// [R10] tolerates held-low serial clock, never stretches it
// [R11] 25 ms of bus silence returns the interface to idle
// [R12] run mode: repeated conversions at rate from configuration low bits
// [R13] standby: no conversions, bus alive, one-shot runs one full set
// [R14] after a one-shot set the block falls back to standby by itself
// [R15] 11-bit results in legacy or extended (minus 64 degrees) format
// [R16] three zones, internal and two remote, each with its own result
// [R17] 6-bit writable ideality setting per remote zone
// [R18] high byte read latches matching low byte for a consistent pair
// [R19] undefined addresses read 00h, writes there do nothing
// [R20] one full three-zone conversion set takes 62 ms
// [R21] command byte also loads the pointer for later receive bytes
// [R22] ack by pulling data low in the ninth clock, otherwise released
package sss_pkg;
  localparam int          SSS_CLK_HZ    = 20_000_000;
  localparam int          SSS_TO_MS     = 25;
  localparam int          SSS_CONV_MS   = 62;
  localparam logic [6:0]  SSS_ADDR_DEF  = 7'h2A;  // arbitrary default, set per variant
  localparam logic [6:0]  SSS_ARA_ADDR  = 7'h0C;
  // register read and write addresses
  localparam logic [7:0]  SSS_RD_INT_H  = 8'h00;
  localparam logic [7:0]  SSS_RD_INT_L  = 8'h23;
  localparam logic [7:0]  SSS_RD_R1_H   = 8'h01;
  localparam logic [7:0]  SSS_RD_R1_L   = 8'h10;
  localparam logic [7:0]  SSS_RD_R2_H   = 8'hF8;
  localparam logic [7:0]  SSS_RD_R2_L   = 8'hF9;
  localparam logic [7:0]  SSS_RD_X1_H   = 8'hFA;
  localparam logic [7:0]  SSS_RD_X1_L   = 8'hFB;
  localparam logic [7:0]  SSS_RD_X2_H   = 8'hFC;
  localparam logic [7:0]  SSS_RD_X2_L   = 8'hFD;
  localparam logic [7:0]  SSS_RD_STAT   = 8'h02;
  localparam logic [7:0]  SSS_RD_CFG    = 8'h03;
  localparam logic [7:0]  SSS_WR_CFG    = 8'h09;
  localparam logic [7:0]  SSS_WR_ONESHOT = 8'h0F;
  localparam logic [7:0]  SSS_RW_IDEAL1 = 8'h27;
  localparam logic [7:0]  SSS_RW_IDEAL2 = 8'h28;
  localparam logic [7:0]  SSS_RD_PID    = 8'hED;
  localparam logic [7:0]  SSS_RD_MID    = 8'hFE;
  localparam logic [7:0]  SSS_RD_REV    = 8'hFF;
  // reset values and fields
  localparam logic [7:0]  SSS_CFG_DEF   = 8'h47;
  localparam logic [5:0]  SSS_IDEAL_DEF = 6'h12;
  localparam int          SSS_CFG_STBY  = 6;
  localparam int          SSS_STAT_BUSY = 7;
  // result coding, units of 0.125 degree, and conversion gap base
  localparam logic [10:0]        SSS_FAULT_CODE = 11'h400;
  localparam logic signed [12:0] SSS_CLIP_LO    = -13'sh01FF;
  localparam logic signed [12:0] SSS_CLIP_X_LO  = -13'sh03FF;
  localparam logic signed [12:0] SSS_CLIP_HI    = 13'sh03FF;
  localparam logic signed [12:0] SSS_EXT_OFS    = 13'sh0200;
  localparam logic [7:0]         SSS_GAP_BASE   = 8'h80;

  typedef struct packed {
    logic              fault;
    logic signed [11:0] raw;
  } sss_zone_t;

  typedef enum logic [2:0] {
    SSS_IDLE = 3'b000, SSS_ADDR = 3'b001, SSS_AACK = 3'b011, SSS_RXB = 3'b010,
    SSS_RACK = 3'b110, SSS_TXB = 3'b111, SSS_TACK = 3'b101, SSS_IGNR = 3'b100
  } sss_bus_st_t;

  typedef enum logic [1:0] {
    SSS_C_IDLE = 2'b00, SSS_C_CONV = 2'b01, SSS_C_GAP = 2'b11
  } sss_conv_st_t;
endpackage

// File: rtl/sss_sensor_slave.sv
// module: two-wire slave interface, byte registers and conversion sequencing
module sss_sensor_slave #(
  parameter int         TO_CYC     = sss_pkg::SSS_TO_MS * (sss_pkg::SSS_CLK_HZ / 1000),
  parameter int         CONV_CYC   = sss_pkg::SSS_CONV_MS * (sss_pkg::SSS_CLK_HZ / 1000),
  parameter logic [6:0] SLAVE_ADDR = sss_pkg::SSS_ADDR_DEF,
  parameter logic [7:0] PROD_ID    = 8'hA1,  // arbitrary value
  parameter logic [7:0] MFR_ID     = 8'hB2,  // arbitrary value
  parameter logic [7:0] REV_ID     = 8'hC3   // arbitrary value
) (
  input  wire logic               mclk_in,
  input  wire logic               rst_n_in,
  input  wire logic               ce_in,
  input  wire logic               serial_clock_pin_in,
  input  wire logic               sda_in,
  input  wire logic               alert_req_in,
  input  wire sss_pkg::sss_zone_t zone_int_in,
  input  wire sss_pkg::sss_zone_t zone_r1_in,
  input  wire sss_pkg::sss_zone_t zone_r2_in,
  output logic                    sda_out,
  output logic                    sda_oe_out,
  output logic                    conv_busy_out,
  output logic                    standby_out,
  output logic [5:0]              ideal1_out,
  output logic [5:0]              ideal2_out
);
  import sss_pkg::*;

  // ============================================================
  // pin synchronisers and edge detection
  logic [2:0]  scl_s_r;
  logic [2:0]  sda_s_r;
  logic        scl_f_r;
  logic        sda_f_r;
  logic        scl_p_r;
  logic        sda_p_r;
  logic        rise;
  logic        fall;
  logic        start_ev;
  logic        stop_ev;
  logic        any_edge;

  // idle bus is high, so reset to high avoids a false start
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else if (ce_in) begin
      scl_s_r <= {scl_s_r[1:0], serial_clock_pin_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
      if (scl_s_r[1] == scl_s_r[2]) scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2]) sda_f_r <= sda_s_r[2];
      scl_p_r <= scl_f_r;
      sda_p_r <= sda_f_r;
    end
  end

  // clock is only watched, a long low phase simply waits
  assign rise     = scl_f_r & ~scl_p_r;  // [R10]
  assign fall     = ~scl_f_r & scl_p_r;
  assign start_ev = scl_f_r & scl_p_r & ~sda_f_r & sda_p_r;
  assign stop_ev  = scl_f_r & scl_p_r & sda_f_r & ~sda_p_r;
  assign any_edge = (scl_f_r ^ scl_p_r) | (sda_f_r ^ sda_p_r);

  // ============================================================
  // register state and read mux
  sss_bus_st_t  st_r;
  sss_conv_st_t cst_r;
  logic [7:0]   ptr_r;
  logic [7:0]   cfg_r;
  logic [5:0]   ideal1_r;
  logic [5:0]   ideal2_r;
  logic         oneshot_r;
  logic [1:0]   flt_r;
  logic [10:0]  res_r [5];
  logic [2:0]   lo_r  [5];
  logic [7:0]   sh_r;
  logic [7:0]   tx_r;
  logic [2:0]   bit_r;
  logic [1:0]   idx_r;
  logic         oe_r;
  logic         drv_r;
  logic         rw_r;
  logic         ara_r;
  logic [20:0]  to_cnt_r;
  logic         to_hit;
  logic [7:0]   rx_byte;
  logic         rx_done;
  logic         tx_load;
  logic [7:0]   tx_nxt;
  logic         standby;

  assign standby = cfg_r[SSS_CFG_STBY];
  assign rx_byte = {sh_r[6:0], sda_f_r};

  // zone index of a result register, 7 when not a result
  function automatic logic [2:0] zone_of(input logic [7:0] a);
    case (a)
      SSS_RD_INT_H, SSS_RD_INT_L: zone_of = 3'h0;
      SSS_RD_R1_H, SSS_RD_R1_L:   zone_of = 3'h1;
      SSS_RD_R2_H, SSS_RD_R2_L:   zone_of = 3'h2;
      SSS_RD_X1_H, SSS_RD_X1_L:   zone_of = 3'h3;
      SSS_RD_X2_H, SSS_RD_X2_L:   zone_of = 3'h4;
      default:                    zone_of = 3'h7;
    endcase
  endfunction

  function automatic logic is_high(input logic [7:0] a);
    is_high = (a == SSS_RD_INT_H) || (a == SSS_RD_R1_H) || (a == SSS_RD_R2_H) ||
              (a == SSS_RD_X1_H) || (a == SSS_RD_X2_H);
  endfunction

  always_comb begin
    logic [2:0] z;
    z = zone_of(ptr_r);
    tx_nxt = 8'h00;  // [R19]
    if (ara_r) begin
      tx_nxt = {SLAVE_ADDR, 1'b0};  // [R7]
    end else if (z != 3'h7) begin
      tx_nxt = is_high(ptr_r) ? res_r[z][10:3] : {lo_r[z], 5'h00};
    end else begin
      case (ptr_r)
        SSS_RD_STAT:   tx_nxt = {conv_busy_out, 5'h00, flt_r};
        SSS_RD_CFG:    tx_nxt = cfg_r;
        SSS_RW_IDEAL1: tx_nxt = {2'h0, ideal1_r};
        SSS_RW_IDEAL2: tx_nxt = {2'h0, ideal2_r};
        SSS_RD_PID:    tx_nxt = PROD_ID;
        SSS_RD_MID:    tx_nxt = MFR_ID;
        SSS_RD_REV:    tx_nxt = REV_ID;
        default:       tx_nxt = 8'h00;  // [R19]
      endcase
    end
  end

  // ============================================================
  // inactivity timeout
  assign to_hit = (to_cnt_r == 21'(TO_CYC - 1));

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      to_cnt_r <= '0;
    end else if (ce_in) begin
      if (st_r == SSS_IDLE || any_edge || to_hit) to_cnt_r <= '0;  // [R11]
      else to_cnt_r <= to_cnt_r + 21'h1;
    end
  end

  // ============================================================
  // bus state machine
  assign rx_done = (st_r == SSS_RXB) && rise && (bit_r == 3'h7) && (idx_r < 2'h2);
  assign tx_load = (st_r == SSS_AACK) && fall && drv_r && rw_r;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r  <= SSS_IDLE;
      sh_r  <= 8'h00;
      tx_r  <= 8'h00;
      bit_r <= 3'h0;
      idx_r <= 2'h0;
      oe_r  <= 1'b0;
      drv_r <= 1'b0;
      rw_r  <= 1'b0;
      ara_r <= 1'b0;
    end else if (ce_in) begin
      if (to_hit) begin
        st_r <= SSS_IDLE;  // [R11]
        oe_r <= 1'b0;
      end else if (start_ev) begin
        st_r  <= SSS_ADDR;
        bit_r <= 3'h0;
        oe_r  <= 1'b0;
        drv_r <= 1'b0;
      end else if (stop_ev) begin
        st_r <= SSS_IDLE;
        oe_r <= 1'b0;
      end else begin
        case (st_r)
          SSS_ADDR: if (rise) begin
            sh_r  <= rx_byte;
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7) begin
              rw_r  <= sda_f_r;
              idx_r <= 2'h0;
              ara_r <= (sh_r[6:0] == SSS_ARA_ADDR);
              if (sh_r[6:0] == SLAVE_ADDR) st_r <= SSS_AACK;  // [R8]
              else if (sh_r[6:0] == SSS_ARA_ADDR && sda_f_r && alert_req_in) st_r <= SSS_AACK;  // [R7]
              else st_r <= SSS_IGNR;  // [R9]
            end
          end
          SSS_AACK: if (fall) begin
            if (!drv_r) begin
              oe_r  <= 1'b1;  // [R22]
              drv_r <= 1'b1;
            end else begin
              drv_r <= 1'b0;
              bit_r <= 3'h0;
              if (rw_r) begin
                oe_r <= ~tx_nxt[7];
                tx_r <= {tx_nxt[6:0], 1'b0};
                st_r <= SSS_TXB;
              end else begin
                oe_r <= 1'b0;  // [R22]
                st_r <= SSS_RXB;
              end
            end
          end
          SSS_RXB: if (rise) begin
            sh_r  <= rx_byte;
            bit_r <= bit_r + 3'h1;
            // a third byte is not a supported sequence
            if (bit_r == 3'h7) st_r <= (idx_r < 2'h2) ? SSS_RACK : SSS_IGNR;  // [R9]
          end
          SSS_RACK: if (fall) begin
            if (!drv_r) begin
              oe_r  <= 1'b1;  // [R22]
              drv_r <= 1'b1;
            end else begin
              oe_r  <= 1'b0;
              drv_r <= 1'b0;
              bit_r <= 3'h0;
              idx_r <= idx_r + 2'h1;
              st_r  <= SSS_RXB;
            end
          end
          SSS_TXB: begin
            if (rise) begin
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) st_r <= SSS_TACK;
            end
            // data changes only with the clock low, so no start or stop is ever made
            if (fall) begin
              oe_r <= ~tx_r[7];  // [R6] [R2]
              tx_r <= {tx_r[6:0], 1'b0};
            end
          end
          SSS_TACK: begin
            if (fall) oe_r <= 1'b0;
            // one byte per read; a host ack asks for more than is supported
            if (rise) st_r <= SSS_IGNR;  // [R2]
          end
          SSS_IGNR: oe_r <= 1'b0;  // [R9]
          default: st_r <= SSS_IDLE;
        endcase
      end
    end
  end

  assign sda_out    = 1'b0;
  assign sda_oe_out = oe_r;

  // ============================================================
  // pointer and writable registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_r     <= 8'h00;
      cfg_r     <= SSS_CFG_DEF;
      ideal1_r  <= SSS_IDEAL_DEF;
      ideal2_r  <= SSS_IDEAL_DEF;
      oneshot_r <= 1'b0;
    end else if (ce_in) begin
      if (cst_r == SSS_C_CONV) oneshot_r <= 1'b0;
      if (rx_done && idx_r == 2'h0) ptr_r <= rx_byte;  // [R21] [R3] [R5]
      if (rx_done && idx_r == 2'h1) begin
        case (ptr_r)  // [R1]
          SSS_WR_CFG:     cfg_r <= rx_byte;
          SSS_WR_ONESHOT: if (standby) oneshot_r <= 1'b1;  // [R13]
          SSS_RW_IDEAL1:  ideal1_r <= rx_byte[5:0];  // [R17]
          SSS_RW_IDEAL2:  ideal2_r <= rx_byte[5:0];  // [R17]
          default: ;  // [R19]
        endcase
      end
    end
  end

  assign ideal1_out  = ideal1_r;
  assign ideal2_out  = ideal2_r;
  assign standby_out = standby;

  // ============================================================
  // conversion sequencing and result capture
  logic [20:0] ccnt_r;
  logic [7:0]  slot_r;
  logic        cend;
  logic [7:0]  gap_slots;

  assign cend      = (ccnt_r == 21'(CONV_CYC - 1));
  assign gap_slots = SSS_GAP_BASE >> cfg_r[2:0];  // [R12]

  function automatic logic [10:0] clip(input logic signed [12:0] x, input logic signed [12:0] lo);
    if (x < lo) clip = lo[10:0];
    else if (x > SSS_CLIP_HI) clip = SSS_CLIP_HI[10:0];
    else clip = x[10:0];
  endfunction

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cst_r  <= SSS_C_IDLE;
      ccnt_r <= '0;
      slot_r <= 8'h00;
    end else if (ce_in) begin
      case (cst_r)
        SSS_C_IDLE: begin
          ccnt_r <= '0;
          if (!standby || oneshot_r) cst_r <= SSS_C_CONV;  // [R12] [R13]
        end
        SSS_C_CONV: begin
          ccnt_r <= cend ? '0 : ccnt_r + 21'h1;  // [R20]
          slot_r <= 8'h00;
          if (cend) cst_r <= standby ? SSS_C_IDLE : SSS_C_GAP;  // [R14]
        end
        SSS_C_GAP: begin
          ccnt_r <= cend ? '0 : ccnt_r + 21'h1;
          if (cend) slot_r <= slot_r + 8'h01;
          if (standby) cst_r <= SSS_C_IDLE;
          else if (cend && slot_r + 8'h01 >= gap_slots) cst_r <= SSS_C_CONV;  // [R12]
        end
        default: cst_r <= SSS_C_IDLE;
      endcase
    end
  end

  assign conv_busy_out = (cst_r == SSS_C_CONV);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flt_r <= 2'h0;
      for (int i = 0; i < 5; i++) begin
        res_r[i] <= 11'h000;
        lo_r[i]  <= 3'h0;
      end
    end else if (ce_in) begin
      if (cst_r == SSS_C_CONV && cend) begin
        flt_r    <= {zone_r2_in.fault, zone_r1_in.fault};
        res_r[0] <= clip(13'(zone_int_in.raw), SSS_CLIP_LO);  // [R16] [R15]
        res_r[1] <= zone_r1_in.fault ? SSS_FAULT_CODE : clip(13'(zone_r1_in.raw), SSS_CLIP_LO);
        res_r[2] <= zone_r2_in.fault ? SSS_FAULT_CODE : clip(13'(zone_r2_in.raw), SSS_CLIP_LO);
        res_r[3] <= zone_r1_in.fault ? SSS_FAULT_CODE :
                    clip(13'(zone_r1_in.raw) - SSS_EXT_OFS, SSS_CLIP_X_LO);  // [R15]
        res_r[4] <= zone_r2_in.fault ? SSS_FAULT_CODE :
                    clip(13'(zone_r2_in.raw) - SSS_EXT_OFS, SSS_CLIP_X_LO);
      end
      if (tx_load && !ara_r && is_high(ptr_r)) lo_r[zone_of(ptr_r)] <= res_r[zone_of(ptr_r)][2:0];  // [R18]
    end
  end

  // ============================================================
  // checks
  sequence ack_slot_s;
    (st_r == SSS_AACK || st_r == SSS_RACK) && drv_r;
  endsequence

  sequence cmd_byte_s;
    rx_done && idx_r == 2'h0 && ce_in;
  endsequence

  chk_oe_clock_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // [R6]
    $changed(oe_r) && !$past(to_hit) |-> !scl_f_r) else $error("data drive changed with clock high");
  chk_ack_drives: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // [R22]
    ack_slot_s |-> oe_r) else $error("ack slot without data pulled low");
  chk_ignore_silent: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // [R9]
    st_r == SSS_IGNR ##1 st_r == SSS_IGNR |-> !oe_r) else $error("drive while ignoring");
  chk_cmd_pointer: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // [R21]
    cmd_byte_s |=> ptr_r == $past(rx_byte)) else $error("pointer not loaded by command");
  chk_rx_ptr_keep: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // [R5]
    st_r == SSS_TXB ##1 st_r == SSS_TXB |-> $stable(ptr_r)) else $error("pointer moved during read");
  chk_timeout_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // [R11]
    to_hit && ce_in |=> st_r == SSS_IDLE && !oe_r) else $error("timeout did not idle");
  chk_oneshot_back: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // [R14]
    cst_r == SSS_C_CONV && cend && standby && ce_in |=> cst_r == SSS_C_IDLE) else $error("no return to standby");
  chk_standby_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // [R13]
    cst_r == SSS_C_IDLE && standby && !oneshot_r |=> cst_r != SSS_C_CONV) else $error("conversion in standby");
  chk_ideal_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // [R17]
    rx_done && idx_r == 2'h1 && ptr_r == SSS_RW_IDEAL1 && ce_in |=> ideal1_r == $past(rx_byte[5:0]))
    else $error("ideality write lost");
  chk_run_restart: assert property (@(posedge mclk_in) disable iff (!rst_n_in)  // [R12]
    cst_r == SSS_C_IDLE && !standby && ce_in |=> cst_r == SSS_C_CONV) else $error("run mode did not convert");
endmodule

// File: dv/sss_host_model.sv
// bus host model: drives the serial clock and pulls the data wire low
module sss_host_model (
  input  wire logic mclk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ============================================================
  // pin timing: 400 ns bit, 300 ns low and 100 ns high
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic drive(input logic s, input logic l, input int n);
    scl_out = s;
    sda_low_out = l;
    repeat (n) @(negedge mclk_in);
  endtask
  // data moves two cycles after the fall so the slave's sync delay cannot reorder edges
  task automatic bit_io(input logic b, output logic r);
    drive(1'b0, ~b, 4);
    drive(1'b1, ~b, 1);
    r = sda_in;
    drive(1'b1, ~b, 1);
    drive(1'b0, ~b, 2);
  endtask
  // also a repeated start; long low lets the slave release its ack first
  task automatic start();
    drive(1'b0, 1'b0, 6);
    drive(1'b1, 1'b0, 4);
    drive(1'b1, 1'b1, 4);
    drive(1'b0, 1'b1, 2);
  endtask
  task automatic stop();
    drive(1'b0, 1'b1, 6);
    drive(1'b1, 1'b1, 4);
    drive(1'b1, 1'b0, 4);
  endtask
  // ninth bit always released: slave acks writes, host nacks reads
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack_bit);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(1'b1, ack_bit);
  endtask
endmodule

// File: dv/test_smbus_sensor_slave_interface.sv
// testbench of the sensor serial slave against the host model
module test_smbus_sensor_slave_interface;
  timeunit 1ns;
  timeprecision 1ns;
  import sss_pkg::*;
  localparam int         TO_C = 200;
  localparam int         CV_C = 50;
  localparam logic [6:0] SA   = 7'h35;  // arbitrary address
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic       alert_req = 1'b0;
  sss_zone_t  z_int, z_r1, z_r2;
  logic       scl, host_low, sda_oe, sda_o, busy, stby, ak;
  logic [5:0] id1, id2;
  logic [7:0] rx;
  int         failures, checks_done, cyc, bcnt, blen, bruns;
  wire        sda = ~(host_low | (sda_oe & ~sda_o));
  // {write, command, data or expected read}
  localparam logic [16:0] ROWS [25] = '{
    {1'b1,8'h27,8'hFF}, {1'b0,8'h27,8'h3F}, {1'b1,8'h28,8'h05}, {1'b0,8'h28,8'h05}, {1'b0,8'h03,8'h47},
    {1'b1,8'h05,8'h77}, {1'b0,8'h05,8'h00}, {1'b1,8'h00,8'h55}, {1'b0,8'h00,8'h00}, {1'b0,8'hED,8'h3C},
    {1'b0,8'hFE,8'h5A}, {1'b0,8'hFF,8'h69}, {1'b1,8'h0F,8'h00}, {1'b0,8'h02,8'h02}, {1'b0,8'h00,8'h19},
    {1'b0,8'h23,8'h60}, {1'b0,8'h01,8'h7F}, {1'b0,8'h10,8'hE0}, {1'b0,8'hF8,8'h80}, {1'b0,8'hF9,8'h00},
    {1'b0,8'hFA,8'h49}, {1'b0,8'hFB,8'h80}, {1'b0,8'hFC,8'h80}, {1'b0,8'hFD,8'h00}, {1'b0,8'h03,8'h47}};

  always #25 mclk = ~mclk;

  sss_sensor_slave #(
    .TO_CYC(TO_C), .CONV_CYC(CV_C), .SLAVE_ADDR(SA),
    .PROD_ID(8'h3C), .MFR_ID(8'h5A), .REV_ID(8'h69)  // arbitrary values
  ) u_sss_sensor_slave (
    .mclk_in(mclk), .rst_n_in(rst_n), .ce_in(ce), .serial_clock_pin_in(scl), .sda_in(sda),
    .alert_req_in(alert_req), .zone_int_in(z_int), .zone_r1_in(z_r1), .zone_r2_in(z_r2),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .conv_busy_out(busy), .standby_out(stby),
    .ideal1_out(id1), .ideal2_out(id2));

  sss_host_model u_sss_host_model (.mclk_in(mclk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));

  // ============================================================
  // checking and bus helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic acked);
    u_sss_host_model.byte_io(b, rx, ak);
    chk({7'h0, ak}, {7'h0, ~acked});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, input logic acked);
    u_sss_host_model.start();
    put(a, acked);
    put(c, acked);
    put(d, acked);
    u_sss_host_model.stop();
  endtask
  // snd high: read byte; low: receive byte at the pointer
  task automatic rd(input logic [7:0] c, input logic snd);
    u_sss_host_model.start();
    if (snd) begin
      put({SA, 1'b0}, 1'b1);
      put(c, 1'b1);
      u_sss_host_model.start();
    end
    put({SA, 1'b1}, 1'b1);
    u_sss_host_model.byte_io(8'hFF, rx, ak);
    u_sss_host_model.stop();
  endtask
  task automatic rst_chk();
    chk({5'h0, stby, busy, sda_oe}, 8'h04);
    chk({id1, id2[5:4]}, {6'h12, 2'h1});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // run length of the last conversion set
  always @(negedge mclk) begin
    cyc++;
    if (busy === 1'b1) bcnt++;
    else if (bcnt != 0) begin
      blen = bcnt;
      bruns++;
      bcnt = 0;
    end
    if (cyc == 40000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    z_int = '{fault: 1'b0, raw: 12'sh0CB};
    z_r1 = '{fault: 1'b0, raw: 12'sh44C};
    z_r2 = '{fault: 1'b1, raw: 12'sh000};
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    rst_chk();
    for (int i = 0; i < 25; i++) begin
      if (ROWS[i][16]) wr({SA, 1'b0}, ROWS[i][15:8], ROWS[i][7:0], 1'b1);
      else begin
        rd(ROWS[i][15:8], 1'b1);
        chk(rx, ROWS[i][7:0]);
      end
    end
    // one-shot from standby: one set of the set length, then standby again
    chk(8'(blen), 8'(CV_C));
    chk(8'(bruns), 8'h01);
    chk({7'h0, stby}, 8'h01);
    chk({id1, id2[1:0]}, {6'h3F, 2'h1});
    // pointer loads without writes, receives repeat the same register
    u_sss_host_model.start();
    put({SA, 1'b0}, 1'b1);
    put(8'h27, 1'b1);
    u_sss_host_model.stop();
    rd(8'h00, 1'b0);
    chk(rx, 8'h3F);
    rd(8'h00, 1'b0);
    chk(rx, 8'h3F);
    rd(8'h28, 1'b1);
    rd(8'h00, 1'b0);
    chk(rx, 8'h05);
    // foreign address: silent and harmless
    wr({SA ^ 7'h01, 1'b0}, 8'h28, 8'h3A, 1'b0);
    rd(8'h28, 1'b1);
    chk(rx, 8'h05);
    // alert response only while an alert is pending
    u_sss_host_model.start();
    put({SSS_ARA_ADDR, 1'b1}, 1'b0);
    u_sss_host_model.stop();
    alert_req = 1'b1;
    rd(8'h00, 1'b0);
    u_sss_host_model.start();
    put({SSS_ARA_ADDR, 1'b1}, 1'b1);
    u_sss_host_model.byte_io(8'hFF, rx, ak);
    u_sss_host_model.stop();
    chk(rx, {SA, 1'b0});
    alert_req = 1'b0;
    // host stalls with the clock low while the slave drives a zero
    u_sss_host_model.start();
    put({SA, 1'b1}, 1'b1);
    repeat (20) @(negedge mclk);
    chk({7'h0, sda_oe}, 8'h01);
    // clock enable low freezes the timeout counter too
    ce = 1'b0;
    repeat (TO_C + 10) @(negedge mclk);
    chk({7'h0, sda_oe}, 8'h01);
    ce = 1'b1;
    repeat (TO_C + 10) @(negedge mclk);
    chk({7'h0, sda_oe}, 8'h00);
    u_sss_host_model.stop();
    rd(8'h27, 1'b1);
    chk(rx, 8'h3F);
    // run mode converts on its own
    wr({SA, 1'b0}, 8'h09, 8'h00, 1'b1);
    repeat (CV_C + 10) @(negedge mclk);
    chk({7'h0, stby}, 8'h00);
    chk(8'(bruns), 8'h02);
    // reset in mid-run restores defaults
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_chk();
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    rd(8'h27, 1'b1);
    chk(rx, 8'h12);
    rd(8'h03, 1'b1);
    chk(rx, 8'h47);
    end_of_test();
  end
endmodule
